// >>> core/serial_status_defines.svh
// Register offsets, field positions and reset values for the serial status block.
`ifndef SERIAL_STATUS_DEFINES_SVH
`define SERIAL_STATUS_DEFINES_SVH
`define SER_CTRL_A_ADDR      8'h00
`define SER_STATUS_ADDR      8'h04
`define SER_RX_HOLD_ADDR     8'h08
`define SER_TX_HOLD_ADDR     8'h06
`define BIT_RX_FULL          7
`define BIT_OVERRUN          6
`define BIT_PARITY_ERR       5
`define BIT_FRAMING_ERR      4
`define BIT_RX_IRQ_EN        3
`define BIT_CARRIER          2
`define BIT_TX_EMPTY         1
`define BIT_TX_IRQ_EN        0
`define BIT_ERR_RESET        3
`define STATUS_RESET         8'h00
`endif

// >>> core/serial_status_pkg.sv
// Types shared by the serial status block.
package serial_status_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [7:0] io_addr_t;
    typedef enum logic {
        TX_FREE,
        TX_LOADED
    } tx_state_e;
endpackage

// >>> core/carrier_tracker.sv
// Carrier-detect status bit with hold-until-read and rising-edge event.
module carrier_tracker (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic carrier_in,
    input  wire logic status_read,
    output logic      carrier_bit,
    output logic      carrier_rise
);
    logic carrier_prev_reg;
    logic hold_reg;

    // ========================================================================
    // Edge detection and hold.
    // ========================================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            carrier_prev_reg <= 1'b0;
        end else begin
            carrier_prev_reg <= carrier_in;
        end
    end

    assign carrier_rise = carrier_in & ~carrier_prev_reg; // [RL9]

    // After the input falls the bit stays set until the status register is read.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_reg <= 1'b0; // [RL11]
        end else if (carrier_in) begin
            hold_reg <= 1'b1;
        end else if (status_read) begin
            hold_reg <= 1'b0; // [RL11]
        end
    end

    assign carrier_bit = carrier_in | hold_reg; // [RL10]

    property p_hold_until_read;
        @(posedge clk) disable iff (!nrst)
        $fell(carrier_in) |-> carrier_bit;
    endproperty
    a_hold_until_read: assert property (p_hold_until_read) // [RL11]
        else $error("carrier bit dropped on input fall");
endmodule

// >>> core/serial_status_flags.sv
// Status flags, interrupt enables and interrupt request of serial channel 0.
`include "serial_status_defines.svh"

//
// How it works
// RL1: Receive-full flag bit 7 sets when a byte moves into the holding register.
// RL2: Bytes with framing or parity errors are still loaded and flag full.
// RL3: Receive-full clears on holding read, carrier high, stop mode, reset.
// RL4: Overrun bit 6 sets when holding and shift register are both full and another byte completes.
// RL5: Error flags clear on error-reset write of 0, carrier high, stop, reset.
// RL6: Parity error bit 5 sets only with parity mode enabled and bad parity.
// RL7: Framing error bit 4 sets when the stop bit is sampled low.
// RL8: Receive enable bit 3 requests interrupt when any receive flag is set.
// RL9: With receive enable, a carrier-detect rising edge also requests interrupt.
// RL10: Carrier bit 2 reads 1 while the carrier input is high; read-only.
// RL11: After carrier falls the bit holds until a status read; reset clears.
// RL12: While the carrier bit is 1 the receiver is held in reset.
// RL13: Transmit-empty bit 1 clears on a holding write, sets on transfer.
// RL14: Transmit-empty is forced to 1 in stop mode and reset while clear-to-send is low.
// RL15: Clear-to-send input high holds transmit-empty at 0.
// RL16: Transmit enable bit 0 requests interrupt while transmit-empty is 1.
// RL17: Transmit enable and all other status bits except transmit-empty (bit 1, resets to 1) reset to 0.
// RL18: Status register at I/O 04h; only bits 3 and 0 are writable.
// RL19: Error-flag-reset is bit 3 of control register A at I/O 00h.
// RL20: Overrun is flagged when a new byte completes with the shift register full; the code also requires the holding register to be full.
// RL21: One level interrupt request ORs all enabled conditions.
module serial_status_flags (
    input  wire logic                      REF_CLK,
    input  wire logic                      NRST,
    input  wire serial_status_pkg::io_addr_t IO_ADDR,
    input  wire serial_status_pkg::byte_t  IO_WDATA,
    input  wire logic                      IO_RD,
    input  wire logic                      IO_WR,
    output serial_status_pkg::byte_t       IO_RDATA,
    input  wire logic                      IO_STOP_MODE,
    input  wire logic                      CARRIER_DETECT_IN,
    input  wire logic                      CLEAR_TO_SEND_IN,
    input  wire logic                      PARITY_MODE_SELECT,
    input  wire logic                      RX_BYTE_DONE,
    input  wire logic                      RX_PARITY_BAD,
    input  wire logic                      RX_STOP_BIT,
    input  wire logic                      TX_SHIFT_LOAD,
    output logic                           RX_HOLD_LOAD,
    output logic                           RX_UNIT_RESET,
    output logic                           TX_PENDING,
    output logic                           IRQ
);
    import serial_status_pkg::*;

    logic      rx_full_flag_reg;
    logic      rx_shift_full_reg;
    logic      rx_overrun_flag_reg;
    logic      parity_error_flag_reg;
    logic      framing_error_flag_reg;
    logic      rx_irq_enable_reg;
    logic      tx_irq_enable_reg;
    tx_state_e tx_state_reg;
    logic      tx_empty_flag;
    logic      carrier_bit;
    logic      carrier_rise;
    logic      clear_all;
    logic      status_rd;
    logic      status_wr;
    logic      rx_hold_rd;
    logic      tx_hold_wr;
    logic      err_reset_wr;
    logic      byte_in;
    logic      rx_irq;
    logic      tx_irq;
    byte_t     status_value;
    byte_t     rdata_next;

    // ========================================================================
    // Address decode.
    // ========================================================================
    assign status_rd    = IO_RD && (IO_ADDR == `SER_STATUS_ADDR); // [RL18]
    assign status_wr    = IO_WR && (IO_ADDR == `SER_STATUS_ADDR); // [RL18]
    assign rx_hold_rd   = IO_RD && (IO_ADDR == `SER_RX_HOLD_ADDR);
    assign tx_hold_wr   = IO_WR && (IO_ADDR == `SER_TX_HOLD_ADDR);
    assign err_reset_wr = IO_WR && (IO_ADDR == `SER_CTRL_A_ADDR)
                          && !IO_WDATA[`BIT_ERR_RESET]; // [RL19]

    // ========================================================================
    // Carrier detect.
    // ========================================================================
    carrier_tracker u_carrier (
        .clk          (REF_CLK),
        .nrst         (NRST),
        .carrier_in   (CARRIER_DETECT_IN),
        .status_read  (status_rd),
        .carrier_bit  (carrier_bit),
        .carrier_rise (carrier_rise)
    );

    // Receiver is held in reset while the carrier bit is up.
    assign RX_UNIT_RESET = carrier_bit; // [RL12]
    assign clear_all     = CARRIER_DETECT_IN || IO_STOP_MODE;
    assign byte_in       = RX_BYTE_DONE && !carrier_bit; // [RL12]

    // ========================================================================
    // Receive side.
    // ========================================================================
    // The shift register drains into an empty holding register right away.
    assign RX_HOLD_LOAD = !clear_all && !rx_full_flag_reg
                          && (rx_shift_full_reg || byte_in); // [RL1]

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_full_flag_reg <= 1'b0; // [RL3]
        end else if (clear_all) begin
            rx_full_flag_reg <= 1'b0; // [RL3]
        end else if (RX_HOLD_LOAD) begin
            rx_full_flag_reg <= 1'b1; // [RL1] [RL2]
        end else if (rx_hold_rd) begin
            rx_full_flag_reg <= 1'b0; // [RL3]
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_shift_full_reg <= 1'b0;
        end else if (clear_all) begin
            rx_shift_full_reg <= 1'b0;
        end else if (RX_HOLD_LOAD) begin
            rx_shift_full_reg <= byte_in && rx_shift_full_reg;
        end else if (byte_in) begin
            rx_shift_full_reg <= 1'b1; // [RL4]
        end
    end

    // Error flags: a set in the same cycle as a software clear wins.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_overrun_flag_reg <= 1'b0; // [RL5]
        end else if (clear_all) begin
            rx_overrun_flag_reg <= 1'b0; // [RL5]
        end else if (byte_in && rx_full_flag_reg && rx_shift_full_reg) begin
            rx_overrun_flag_reg <= 1'b1; // [RL4] [RL20]
        end else if (err_reset_wr) begin
            rx_overrun_flag_reg <= 1'b0; // [RL5]
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            parity_error_flag_reg <= 1'b0; // [RL5]
        end else if (clear_all) begin
            parity_error_flag_reg <= 1'b0; // [RL5]
        end else if (byte_in && PARITY_MODE_SELECT && RX_PARITY_BAD) begin
            parity_error_flag_reg <= 1'b1; // [RL6]
        end else if (err_reset_wr) begin
            parity_error_flag_reg <= 1'b0; // [RL5]
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            framing_error_flag_reg <= 1'b0; // [RL5]
        end else if (clear_all) begin
            framing_error_flag_reg <= 1'b0; // [RL5]
        end else if (byte_in && !RX_STOP_BIT) begin
            framing_error_flag_reg <= 1'b1; // [RL7]
        end else if (err_reset_wr) begin
            framing_error_flag_reg <= 1'b0; // [RL5]
        end
    end

    // ========================================================================
    // Transmit side.
    // ========================================================================
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            tx_state_reg <= TX_FREE; // [RL14]
        end else if (IO_STOP_MODE) begin
            tx_state_reg <= TX_FREE; // [RL14]
        end else begin
            unique case (tx_state_reg)
                TX_FREE: begin
                    if (tx_hold_wr) begin
                        tx_state_reg <= TX_LOADED; // [RL13]
                    end
                end
                TX_LOADED: begin
                    if (TX_SHIFT_LOAD) begin
                        tx_state_reg <= TX_FREE; // [RL13]
                    end
                end
            endcase
        end
    end

    assign TX_PENDING    = (tx_state_reg == TX_LOADED);
    assign tx_empty_flag = (tx_state_reg == TX_FREE) && !CLEAR_TO_SEND_IN; // [RL15]

    // ========================================================================
    // Enables and status read.
    // ========================================================================
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_irq_enable_reg <= 1'b0; // [RL17]
            tx_irq_enable_reg <= 1'b0; // [RL17]
        end else if (status_wr) begin
            rx_irq_enable_reg <= IO_WDATA[`BIT_RX_IRQ_EN]; // [RL18]
            tx_irq_enable_reg <= IO_WDATA[`BIT_TX_IRQ_EN]; // [RL18]
        end
    end

    assign status_value = {rx_full_flag_reg, rx_overrun_flag_reg, parity_error_flag_reg,
                           framing_error_flag_reg, rx_irq_enable_reg, carrier_bit,
                           tx_empty_flag, tx_irq_enable_reg};

    always_comb begin
        rdata_next = 8'h00;
        if (status_rd) begin
            rdata_next = status_value;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            IO_RDATA <= `STATUS_RESET;
        end else begin
            IO_RDATA <= rdata_next;
        end
    end

    // ========================================================================
    // Interrupt request.
    // ========================================================================
    assign rx_irq = rx_irq_enable_reg && (rx_full_flag_reg || rx_overrun_flag_reg
                    || parity_error_flag_reg || framing_error_flag_reg
                    || carrier_rise); // [RL8] [RL9]
    assign tx_irq = tx_irq_enable_reg && tx_empty_flag; // [RL16]
    assign IRQ    = rx_irq || tx_irq; // [RL21]

    // ========================================================================
    // Checks.
    // ========================================================================
    property p_full_on_load;
        @(posedge REF_CLK) disable iff (!NRST)
        RX_HOLD_LOAD |=> rx_full_flag_reg;
    endproperty
    a_full_on_load: assert property (p_full_on_load) // [RL1]
        else $error("full flag not set after load");

    property p_full_clear;
        @(posedge REF_CLK) disable iff (!NRST)
        CARRIER_DETECT_IN |=> !rx_full_flag_reg;
    endproperty
    a_full_clear: assert property (p_full_clear) // [RL3]
        else $error("full flag survived carrier high");

    property p_full_read_clear;
        @(posedge REF_CLK) disable iff (!NRST)
        (rx_hold_rd && rx_full_flag_reg) |=> !rx_full_flag_reg;
    endproperty
    a_full_read_clear: assert property (p_full_read_clear) // [RL3]
        else $error("full flag survived holding read");

    property p_overrun;
        @(posedge REF_CLK) disable iff (!NRST)
        (byte_in && rx_full_flag_reg && rx_shift_full_reg && !clear_all)
        |=> rx_overrun_flag_reg;
    endproperty
    a_overrun: assert property (p_overrun) // [RL4]
        else $error("overrun not flagged");

    property p_err_clear;
        @(posedge REF_CLK) disable iff (!NRST)
        (err_reset_wr && !byte_in) |=> !parity_error_flag_reg && !framing_error_flag_reg;
    endproperty
    a_err_clear: assert property (p_err_clear) // [RL5]
        else $error("error flags not cleared");

    property p_parity_gate;
        @(posedge REF_CLK) disable iff (!NRST)
        $rose(parity_error_flag_reg) |-> $past(PARITY_MODE_SELECT);
    endproperty
    a_parity_gate: assert property (p_parity_gate) // [RL6]
        else $error("parity error without parity mode");

    property p_framing;
        @(posedge REF_CLK) disable iff (!NRST)
        (byte_in && !RX_STOP_BIT && !clear_all) |=> framing_error_flag_reg;
    endproperty
    a_framing: assert property (p_framing) // [RL7]
        else $error("framing error not flagged");

    property p_rx_irq;
        @(posedge REF_CLK) disable iff (!NRST)
        (rx_irq_enable_reg && rx_full_flag_reg) |-> IRQ;
    endproperty
    a_rx_irq: assert property (p_rx_irq) // [RL8]
        else $error("receive interrupt missing");

    property p_carrier_irq;
        @(posedge REF_CLK) disable iff (!NRST)
        (rx_irq_enable_reg && $rose(CARRIER_DETECT_IN)) |-> IRQ;
    endproperty
    a_carrier_irq: assert property (p_carrier_irq) // [RL9]
        else $error("carrier rise interrupt missing");

    property p_rx_inhibit;
        @(posedge REF_CLK) disable iff (!NRST)
        carrier_bit |-> RX_UNIT_RESET && !RX_HOLD_LOAD;
    endproperty
    a_rx_inhibit: assert property (p_rx_inhibit) // [RL12]
        else $error("receiver active with carrier bit set");

    property p_tx_write;
        @(posedge REF_CLK) disable iff (!NRST)
        (tx_hold_wr && !IO_STOP_MODE && tx_state_reg == TX_FREE) |=> !tx_empty_flag;
    endproperty
    a_tx_write: assert property (p_tx_write) // [RL13]
        else $error("transmit-empty not cleared by write");

    property p_tx_refill;
        @(posedge REF_CLK) disable iff (!NRST)
        (tx_state_reg == TX_LOADED && TX_SHIFT_LOAD && !IO_STOP_MODE)
        |=> tx_empty_flag || CLEAR_TO_SEND_IN;
    endproperty
    a_tx_refill: assert property (p_tx_refill) // [RL13]
        else $error("transmit-empty not set after shift load");

    property p_stop_empty;
        @(posedge REF_CLK) disable iff (!NRST)
        IO_STOP_MODE |=> tx_empty_flag || CLEAR_TO_SEND_IN;
    endproperty
    a_stop_empty: assert property (p_stop_empty) // [RL14]
        else $error("transmit-empty not forced in stop mode");

    property p_cts;
        @(posedge REF_CLK) disable iff (!NRST)
        CLEAR_TO_SEND_IN |-> !tx_empty_flag;
    endproperty
    a_cts: assert property (p_cts) // [RL15]
        else $error("transmit-empty set with clear-to-send high");

    property p_tx_irq;
        @(posedge REF_CLK) disable iff (!NRST)
        (tx_irq_enable_reg && tx_empty_flag) |-> IRQ;
    endproperty
    a_tx_irq: assert property (p_tx_irq) // [RL16]
        else $error("transmit interrupt missing");

    property p_enable_write;
        @(posedge REF_CLK) disable iff (!NRST)
        status_wr |=> (rx_irq_enable_reg == $past(IO_WDATA[`BIT_RX_IRQ_EN]))
        && (tx_irq_enable_reg == $past(IO_WDATA[`BIT_TX_IRQ_EN]));
    endproperty
    a_enable_write: assert property (p_enable_write) // [RL18]
        else $error("interrupt enables not written");
endmodule

// >>> tb/remote_uart_model.sv
// Far-side receive and transmit shift units feeding the serial status block.
module remote_uart_model (
    input  wire logic clk,
    input  wire logic tx_pending,
    input  wire logic hold_load,
    output logic      rx_done,
    output logic      rx_parity_bad,
    output logic      rx_stop_bit,
    output logic      tx_shift_load
);
    timeunit 1ns;
    timeprecision 1ns;
    int tx_wait;

    initial begin
        rx_done = 1'b0;
        rx_parity_bad = 1'b1;
        rx_stop_bit = 1'b0;
        tx_shift_load = 1'b0;
        tx_wait = 0;
    end

    // ==========================================================
    // Receive side
    // Qualifiers show the inverse of the frame's values outside the done pulse.
    task automatic send_frame(input logic bad, input logic stop, output logic loaded);
        repeat (8) @(negedge clk);
        rx_parity_bad = bad;
        rx_stop_bit = stop;
        rx_done = 1'b1;
        #1 loaded = hold_load;
        @(negedge clk);
        rx_done = 1'b0;
        rx_parity_bad = ~bad;
        rx_stop_bit = ~stop;
    endtask

    // ==========================================================
    // Transmit side
    // The shift register takes a waiting byte after four cycles.
    always @(negedge clk) begin
        tx_shift_load <= tx_pending && (tx_wait == 3);
        tx_wait <= (tx_pending && !tx_shift_load) ? tx_wait + 1 : 0;
    end
endmodule

// >>> tb/tb_serial_status_flags.sv
// Self-checking testbench for the serial status flags block.
module tb_serial_status_flags;
    timeunit 1ns;
    timeprecision 1ns;
    import serial_status_pkg::*;

    logic  ref_clk = 1'b0;
    logic  nrst = 1'b0;
    io_addr_t io_addr = 8'h00;
    byte_t io_wdata = 8'h00;
    logic  io_rd = 1'b0;
    logic  io_wr = 1'b0;
    byte_t io_rdata;
    logic  stop_mode = 1'b0;
    logic  carrier = 1'b0;
    logic  cts = 1'b0;
    logic  par_mode = 1'b0;
    logic  rx_done, rx_par, rx_stop, tx_load, hold_load, unit_reset, tx_pending, irq;
    int    num_errors = 0;
    int    tests_run = 0;

    always #10 ref_clk = ~ref_clk;

    serial_status_flags u_dut (
        .REF_CLK(ref_clk), .NRST(nrst), .IO_ADDR(io_addr), .IO_WDATA(io_wdata),
        .IO_RD(io_rd), .IO_WR(io_wr), .IO_RDATA(io_rdata), .IO_STOP_MODE(stop_mode),
        .CARRIER_DETECT_IN(carrier), .CLEAR_TO_SEND_IN(cts),
        .PARITY_MODE_SELECT(par_mode), .RX_BYTE_DONE(rx_done), .RX_PARITY_BAD(rx_par),
        .RX_STOP_BIT(rx_stop), .TX_SHIFT_LOAD(tx_load), .RX_HOLD_LOAD(hold_load),
        .RX_UNIT_RESET(unit_reset), .TX_PENDING(tx_pending), .IRQ(irq)
    );

    remote_uart_model u_uart (
        .clk(ref_clk), .tx_pending(tx_pending), .hold_load(hold_load),
        .rx_done(rx_done), .rx_parity_bad(rx_par), .rx_stop_bit(rx_stop),
        .tx_shift_load(tx_load)
    );

    // ==========================================================
    // Compare and bus tasks
    task automatic chk8(input byte_t got, input byte_t exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic wr(input io_addr_t a, input byte_t d);
        @(negedge ref_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge ref_clk);
        io_wr = 1'b0;
    endtask

    task automatic rd_chk(input io_addr_t a, input byte_t exp);
        @(negedge ref_clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge ref_clk);
        io_rd = 1'b0;
        chk8(io_rdata, exp);
    endtask

    task automatic send(input logic bad, input logic stop, input logic exp_load);
        logic ld;
        u_uart.send_frame(bad, stop, ld);
        chk1(ld, exp_load);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd_chk(8'h04, 8'h02);
        chk1(irq, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_enables;
        wr(8'h04, 8'hff);
        rd_chk(8'h04, 8'h0b);
        chk1(irq, 1'b1);
        wr(8'h04, 8'h00);
        chk1(irq, 1'b0);
        $display("test enables done");
    endtask

    task automatic t_carrier;
        wr(8'h04, 8'h08);
        carrier = 1'b1;
        // The carrier event request lasts only until the next clock edge.
        #1;
        chk1(irq, 1'b1);
        @(negedge ref_clk);
        chk1(irq, 1'b0);
        chk1(unit_reset, 1'b1);
        send(1'b0, 1'b1, 1'b0);
        rd_chk(8'h04, 8'h0e);
        carrier = 1'b0;
        rd_chk(8'h04, 8'h0e);
        rd_chk(8'h04, 8'h0a);
        chk1(unit_reset, 1'b0);
        $display("test carrier done");
    endtask

    task automatic t_receive;
        send(1'b1, 1'b1, 1'b1);
        rd_chk(8'h04, 8'h8a);
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h04, 8'h0a);
        par_mode = 1'b1;
        send(1'b1, 1'b0, 1'b1);
        rd_chk(8'h04, 8'hba);
        chk1(irq, 1'b1);
        send(1'b0, 1'b1, 1'b0);
        rd_chk(8'h04, 8'hba);
        send(1'b0, 1'b1, 1'b0);
        rd_chk(8'h04, 8'hfa);
        wr(8'h00, 8'h08);
        rd_chk(8'h04, 8'hfa);
        wr(8'h00, 8'h00);
        rd_chk(8'h04, 8'h8a);
        send(1'b1, 1'b0, 1'b0);
        carrier = 1'b1;
        rd_chk(8'h04, 8'h0e);
        carrier = 1'b0;
        rd_chk(8'h04, 8'h0e);
        wr(8'h04, 8'h00);
        $display("test receive done");
    endtask

    task automatic t_transmit;
        wr(8'h06, 8'h55);
        chk1(tx_pending, 1'b1);
        rd_chk(8'h04, 8'h00);
        repeat (8) @(negedge ref_clk);
        rd_chk(8'h04, 8'h02);
        cts = 1'b1;
        rd_chk(8'h04, 8'h00);
        cts = 1'b0;
        wr(8'h04, 8'h01);
        chk1(irq, 1'b1);
        wr(8'h04, 8'h00);
        $display("test transmit done");
    endtask

    task automatic t_stop;
        send(1'b1, 1'b0, 1'b1);
        wr(8'h06, 8'h3c);
        stop_mode = 1'b1;
        rd_chk(8'h04, 8'h02);
        stop_mode = 1'b0;
        $display("test stop mode done");
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        t_reset();
        t_enables();
        t_carrier();
        t_receive();
        t_transmit();
        t_stop();
        close_out();
    end
endmodule
